// ===== src/phy_irq_cfg.svh
`ifndef PHY_IRQ_CFG_SVH
`define PHY_IRQ_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_BASIC_STATUS    8'h84
`define ADDR_STATUS_SUMMARY  8'hc0
`define ADDR_IRQ_CONTROL     8'hc4
`define ADDR_IRQ_STATUS      8'hc8
`define ADDR_FALSE_CARRIER   8'hd0
`define ADDR_RX_ERROR        8'hd4

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define STS_REMOTE_FAULT     6
`define STS_JABBER           5
`define STS_NEG_DONE         4
`define STS_LOOPBACK         3
`define STS_DUPLEX           2
`define STS_SPEED_10         1
`define STS_LINK             0
`define CTRL_EVENT_ENABLE    1
`define CTRL_TEST_IRQ        0
`define STAT_PENDING         15
`define STAT_MASK_MSB        14
`define STAT_MASK_LSB        9
`define IRQ_CONTROL_RESET    16'h0000
`define IRQ_STATUS_RESET     16'h0000
`define COUNTER_WIDTH        8

// Event vector order matches mask bits 14..9
`define EVT_LINK             5
`define EVT_JABBER           4
`define EVT_REMOTE_FAULT     3
`define EVT_NEG_DONE         2
`define EVT_FALSE_CARRIER    1
`define EVT_RX_ERROR         0
`define EVT_COUNT            6
`endif

// ===== src/phy_irq_pkg.sv
package phy_irq_pkg;

  typedef logic [5:0]  event_vec_t;
  typedef logic [15:0] reg_word_t;

  typedef struct packed {
    logic       event_irq_enable;
    logic       test_irq;
    event_vec_t mask;
    logic       irq_pending_flag;
    logic       rf_latch;
    logic       rf_prev;
    logic       link_prev;
    logic       jabber_prev;
    logic       neg_done_prev;
    reg_word_t  rdata;
  } irq_state_s;

endpackage

// ===== src/event_counter.sv
`timescale 1ns/1ns
`default_nettype none
module event_counter #(
  parameter int WIDTH = 8
)(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             srst,
  // Event and clear
  input  wire logic             count_event,
  input  wire logic             clear,
  // Count and half-full pulse
  output logic [WIDTH-1:0]      value,
  output logic                  half_event
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             half;
  } count_state_s;

  localparam logic [WIDTH-1:0] MAX_COUNT = '1;
  localparam logic [WIDTH-1:0] ONE_COUNT = WIDTH'(1);

  count_state_s st;
  count_state_s nx;

  if (WIDTH < 2 || WIDTH > 16)
  begin : g_width_check
    $error("event_counter WIDTH must lie in 2..16");
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nx = st;
    if (clear)
      nx.count = '0;
    // An event in the clearing cycle is kept as the first count
    if (count_event)
    begin
      if (clear)
        nx.count = ONE_COUNT;
      else if (st.count != MAX_COUNT)
        nx.count = st.count + ONE_COUNT;
    end
    nx.half = nx.count[WIDTH-1] & ~st.count[WIDTH-1];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      st <= '0;
    else
      st <= nx;
  end

  assign value      = st.count;
  assign half_event = st.half;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  saturate_hold_a: assert property (value == MAX_COUNT && !clear |=> value == MAX_COUNT)
    else $error("counter left its maximum without a clear");
  half_mark_a: assert property (!value[WIDTH-1] ##1 value[WIDTH-1] |-> half_event)
    else $error("top bit set without a half-full pulse");

endmodule // event_counter
`default_nettype wire

// ===== src/phy_status_irq.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "phy_irq_cfg.svh"
module phy_status_irq
  import phy_irq_pkg::*;
#(
  parameter int CNT_W = `COUNTER_WIDTH
)(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [15:0]      reg_rdata,
  // Line status
  input  wire logic        link_up,
  input  wire logic        jabber,
  input  wire logic        negotiation_done,
  input  wire logic        remote_fault_rx,
  input  wire logic        loopback_on,
  input  wire logic        full_duplex,
  input  wire logic        speed_10,
  // Counter events
  input  wire logic        false_carrier_event,
  input  wire logic        rx_error_event,
  // Host interrupt status bit
  output logic             host_irq_phy
);

  if (CNT_W < 2 || CNT_W > 16)
  begin : g_cnt_check
    $error("phy_status_irq CNT_W must lie in 2..16");
  end

  irq_state_s st;
  irq_state_s nx;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic sel_basic;
  logic sel_summary;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_fc;
  logic sel_rxe;

  assign sel_basic   = reg_addr == `ADDR_BASIC_STATUS;
  assign sel_summary = reg_addr == `ADDR_STATUS_SUMMARY;
  assign sel_ctrl    = reg_addr == `ADDR_IRQ_CONTROL;
  assign sel_stat    = reg_addr == `ADDR_IRQ_STATUS;
  assign sel_fc      = reg_addr == `ADDR_FALSE_CARRIER;
  assign sel_rxe     = reg_addr == `ADDR_RX_ERROR;

  // ----------------------------------------
  // Error counters
  // ----------------------------------------
  logic [1:0]       cnt_event;
  logic [1:0]       cnt_clear;
  logic [1:0]       cnt_half;
  logic [CNT_W-1:0] cnt_value [2];

  assign cnt_event[1] = false_carrier_event;
  assign cnt_event[0] = rx_error_event;
  // Counters clear on read; the read data carry the count before the clear
  assign cnt_clear[1] = reg_read & sel_fc;
  assign cnt_clear[0] = reg_read & sel_rxe;

  // Both counters are the same block; only their event and clear sources differ
  for (genvar i = 0; i < 2; i++)
  begin : g_counter
    event_counter #(
      .WIDTH (CNT_W)
    ) event_counter_i (
      .clock       (clock),
      .srst        (srst),
      .count_event (cnt_event[i]),
      .clear       (cnt_clear[i]),
      .value       (cnt_value[i]),
      .half_event  (cnt_half[i])
    );
  end

  // ----------------------------------------
  // Events and interrupt qualification
  // ----------------------------------------
  event_vec_t events;
  event_vec_t qualified;
  logic       test_fire;
  logic       pending_set;
  reg_word_t  summary_word;
  reg_word_t  ctrl_word;
  reg_word_t  stat_word;

  // Level inputs become one-cycle events against last cycle's value
  always_comb
  begin
    events                     = '0;
    events[`EVT_LINK]          = link_up ^ st.link_prev;
    events[`EVT_JABBER]        = jabber & ~st.jabber_prev;
    events[`EVT_REMOTE_FAULT]  = st.rf_latch & ~st.rf_prev;
    events[`EVT_NEG_DONE]      = negotiation_done & ~st.neg_done_prev;
    events[`EVT_FALSE_CARRIER] = cnt_half[1];
    events[`EVT_RX_ERROR]      = cnt_half[0];
  end

  assign qualified   = events & ~st.mask & {`EVT_COUNT{st.event_irq_enable}};
  // The test source bypasses the event enable on purpose
  assign test_fire   = reg_read & st.test_irq;
  assign pending_set = (|qualified) | test_fire;

  // ----------------------------------------
  // Read views
  // ----------------------------------------
  always_comb
  begin
    summary_word                    = '0;
    summary_word[`STS_REMOTE_FAULT] = st.rf_latch;
    summary_word[`STS_JABBER]       = jabber;
    summary_word[`STS_NEG_DONE]     = negotiation_done;
    summary_word[`STS_LOOPBACK]     = loopback_on;
    summary_word[`STS_DUPLEX]       = full_duplex;
    summary_word[`STS_SPEED_10]     = speed_10;
    summary_word[`STS_LINK]         = link_up;
  end

  always_comb
  begin
    ctrl_word                      = '0;
    ctrl_word[`CTRL_EVENT_ENABLE]  = st.event_irq_enable;
    ctrl_word[`CTRL_TEST_IRQ]      = st.test_irq;
    stat_word                      = '0;
    stat_word[`STAT_PENDING]       = st.irq_pending_flag;
    stat_word[`STAT_MASK_MSB:`STAT_MASK_LSB] = st.mask;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nx               = st;
    nx.link_prev     = link_up;
    nx.jabber_prev   = jabber;
    nx.neg_done_prev = negotiation_done;
    nx.rf_prev       = st.rf_latch;

    // A fault reported in the clearing cycle survives the read
    if (reg_read && sel_basic)
      nx.rf_latch = 1'b0;
    if (remote_fault_rx)
      nx.rf_latch = 1'b1;

    // Only the two low control bits and the mask field take writes
    if (reg_write && sel_ctrl)
    begin
      nx.event_irq_enable = reg_wdata[`CTRL_EVENT_ENABLE];
      nx.test_irq         = reg_wdata[`CTRL_TEST_IRQ];
    end
    if (reg_write && sel_stat)
      nx.mask = reg_wdata[`STAT_MASK_MSB:`STAT_MASK_LSB];

    // New causes win over the clearing read
    if (reg_read && sel_stat)
      nx.irq_pending_flag = 1'b0;
    if (pending_set)
      nx.irq_pending_flag = 1'b1;

    // Read data stand for exactly one cycle
    nx.rdata = '0;
    if (reg_read)
    begin
      case (1'b1)
        sel_summary: nx.rdata = summary_word;
        sel_ctrl:    nx.rdata = ctrl_word;
        sel_stat:    nx.rdata = stat_word;
        sel_fc:      nx.rdata = reg_word_t'(cnt_value[1]);
        sel_rxe:     nx.rdata = reg_word_t'(cnt_value[0]);
        default:     nx.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      st <= '0;
    else
      st <= nx;
  end

  // Both outputs leave flops, so the host never sees a decode glitch
  assign reg_rdata    = st.rdata;
  assign host_irq_phy = st.irq_pending_flag;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // Plain copies of state fields and write data, plus one reduction, so that $past only ever sees a signal
  logic [5:0]       wdata_mask;
  logic [1:0]       wdata_ctrl;
  logic [5:0]       mask_now;
  logic             enable_now;
  logic             test_now;
  logic             rf_now;
  logic             unmasked_any;
  logic [CNT_W-1:0] fc_count;
  logic [CNT_W-1:0] rxe_count;

  assign wdata_mask   = reg_wdata[`STAT_MASK_MSB:`STAT_MASK_LSB];
  assign wdata_ctrl   = {reg_wdata[`CTRL_EVENT_ENABLE], reg_wdata[`CTRL_TEST_IRQ]};
  assign mask_now     = st.mask;
  assign enable_now   = st.event_irq_enable;
  assign test_now     = st.test_irq;
  assign rf_now       = st.rf_latch;
  assign unmasked_any = |(events & ~st.mask);
  assign fc_count     = cnt_value[1];
  assign rxe_count    = cnt_value[0];

  // A source reaches the flag only while its mask is open and events are enabled
  sequence open_source(int idx);
    !st.mask[idx] && st.event_irq_enable;
  endsequence

  sequence no_cause;
    !(unmasked_any && st.event_irq_enable) && !test_fire;
  endsequence

  sequence read_of(logic sel);
    reg_read && sel;
  endsequence

  sequence quiet_status;
    !(reg_read && sel_stat) && !pending_set;
  endsequence

  rf_latch_set_a: assert property (remote_fault_rx |=> summary_word[`STS_REMOTE_FAULT])
    else $error("remote fault not latched");
  rf_latch_clear_a: assert property (read_of(sel_basic) and !remote_fault_rx |=> !st.rf_latch)
    else $error("remote fault survived basic status read");
  rf_hold_a: assert property (st.rf_latch && !(reg_read && sel_basic) |=> st.rf_latch)
    else $error("remote fault dropped without a read");
  summary_live_a: assert property (read_of(sel_summary) |=> reg_rdata[6:0] == {
      $past(rf_now), $past(jabber), $past(negotiation_done), $past(loopback_on),
      $past(full_duplex), $past(speed_10), $past(link_up)})
    else $error("status summary does not match line status");
  summary_reserved_a: assert property (read_of(sel_summary) |=> reg_rdata[15:7] == 9'h000)
    else $error("status summary upper bits not zero");
  ctrl_reserved_a: assert property (read_of(sel_ctrl) |=> reg_rdata[15:2] == 14'h0000)
    else $error("control reserved bits not zero");
  stat_reserved_a: assert property (read_of(sel_stat) |=> reg_rdata[8:0] == 9'h000)
    else $error("status low bits not zero");
  test_irq_fire_a: assert property (reg_read && st.test_irq |=> host_irq_phy)
    else $error("test interrupt missing after read");
  event_gate_a: assert property ($rose(host_irq_phy) |->
      ($past(unmasked_any) && $past(enable_now)) || $past(test_fire))
    else $error("pending flag rose without an enabled cause");
  event_seen_a: assert property (|events && st.event_irq_enable && |(events & ~st.mask)
      |=> host_irq_phy)
    else $error("enabled unmasked event was lost");
  pending_clear_a: assert property (read_of(sel_stat) and !pending_set |=> !host_irq_phy)
    else $error("pending flag not cleared by read");
  pending_hold_a: assert property (host_irq_phy ##0 quiet_status |=> host_irq_phy)
    else $error("pending flag dropped without a read");
  mask_write_a: assert property (reg_write && sel_stat |=>
      mask_now == $past(wdata_mask))
    else $error("mask field did not take the write");

  // Register views and write paths
  ctrl_write_a: assert property (reg_write && sel_ctrl |=> {enable_now, test_now} == $past(wdata_ctrl))
    else $error("control bits did not take the write");
  ctrl_hold_a: assert property (!(reg_write && sel_ctrl) |=> $stable(enable_now) && $stable(test_now))
    else $error("control bits changed without a write");
  mask_hold_a: assert property (!(reg_write && sel_stat) |=> $stable(mask_now))
    else $error("mask field changed without a write");
  ctrl_readback_a: assert property (read_of(sel_ctrl) |=>
      reg_rdata[1:0] == {$past(enable_now), $past(test_now)})
    else $error("control read data do not match the register");
  stat_readback_a: assert property (read_of(sel_stat) |=>
      reg_rdata[15:9] == {$past(host_irq_phy), $past(mask_now)})
    else $error("status read data do not match pending flag and masks");
  fc_read_a: assert property (read_of(sel_fc) |=> reg_rdata == reg_word_t'($past(fc_count)))
    else $error("false carrier read data do not match the count");
  rxe_read_a: assert property (read_of(sel_rxe) |=> reg_rdata == reg_word_t'($past(rxe_count)))
    else $error("receive error read data do not match the count");

  // Reserved and idle read data
  basic_read_zero_a: assert property (read_of(sel_basic) |=> reg_rdata == 16'h0000)
    else $error("basic status read returned data");
  unmapped_read_a: assert property (reg_read && !(sel_summary || sel_ctrl || sel_stat || sel_fc || sel_rxe)
      |=> reg_rdata == 16'h0000)
    else $error("unmapped read returned data");
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 16'h0000)
    else $error("read data stood longer than one cycle");
  write_no_data_a: assert property (reg_write |=> reg_rdata == 16'h0000)
    else $error("write produced read data");

  // The flag stays low without a cause
  no_cause_quiet_a: assert property (!host_irq_phy ##0 no_cause |=> !host_irq_phy)
    else $error("pending flag rose without a cause");
  enable_off_a: assert property (!enable_now && !test_fire && !host_irq_phy |=> !host_irq_phy)
    else $error("disabled events raised the flag");
  mask_all_a: assert property ((&mask_now) && !test_fire && !host_irq_phy |=> !host_irq_phy)
    else $error("fully masked events raised the flag");
  test_off_a: assert property (reg_read && !test_now && !host_irq_phy ##0 no_cause |=> !host_irq_phy)
    else $error("read raised the flag with the test bit off");
  test_no_enable_a: assert property (reg_read && test_now && !enable_now |=> host_irq_phy)
    else $error("test interrupt needed the event enable");
  stat_write_quiet_a: assert property (reg_write && sel_stat && !host_irq_phy ##0 no_cause |=> !host_irq_phy)
    else $error("status write touched the pending flag");

  // Interrupt sources, one by one
  rf_from_fault_a: assert property ($rose(rf_now) |-> $past(remote_fault_rx))
    else $error("remote fault latch set without a report");
  link_event_a: assert property ($changed(link_up) ##0 open_source(`EVT_LINK) |=> host_irq_phy)
    else $error("link change did not raise the flag");
  jabber_event_a: assert property ($rose(jabber) ##0 open_source(`EVT_JABBER) |=> host_irq_phy)
    else $error("jabber did not raise the flag");
  neg_event_a: assert property ($rose(negotiation_done) ##0 open_source(`EVT_NEG_DONE) |=> host_irq_phy)
    else $error("negotiation done did not raise the flag");
  fault_event_a: assert property ($rose(rf_now) ##0 open_source(`EVT_REMOTE_FAULT) |=> host_irq_phy)
    else $error("remote fault did not raise the flag");

  // Per counter: its half-full pulse reaches the flag, and only events or a read move it
  for (genvar i = 0; i < 2; i++)
  begin : g_counter_check
    half_irq_a: assert property (cnt_half[i] ##0 open_source(i) |=> host_irq_phy)
      else $error("counter half-full did not raise the flag");
    count_clear_a: assert property (cnt_clear[i] && !cnt_event[i] |=> cnt_value[i] == '0)
      else $error("counter not emptied by its read");
    count_idle_a: assert property (!cnt_event[i] && !cnt_clear[i] |=> $stable(cnt_value[i]))
      else $error("counter moved without an event or a read");
  end

endmodule // phy_status_irq
`default_nettype wire

// ===== bench/line_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Line side: bursts of counter event pulses
// ----------------------------------------
module line_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Burst request
  input  wire logic       start_fc,
  input  wire logic       start_rx,
  input  wire logic [9:0] length,
  // Event pulses
  output logic            false_carrier_event,
  output logic            rx_error_event,
  output logic            busy
);
  logic [9:0] left_reg;
  logic       rx_sel_reg;
  logic       phase_reg;

  // Pulses every other cycle, as a real line cannot report errors back to back
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      left_reg   <= 10'h000;
      rx_sel_reg <= 1'b0;
      phase_reg  <= 1'b0;
    end
    else if (start_fc || start_rx)
    begin
      left_reg   <= length;
      rx_sel_reg <= start_rx;
      phase_reg  <= 1'b0;
    end
    else if (left_reg != 10'h000)
    begin
      phase_reg <= ~phase_reg;
      if (phase_reg)
        left_reg <= left_reg - 10'h001;
    end
  end

  assign busy                = (left_reg != 10'h000);
  assign false_carrier_event = busy && phase_reg && !rx_sel_reg;
  assign rx_error_event      = busy && phase_reg && rx_sel_reg;
endmodule // line_model
`default_nettype wire

// ===== bench/test_phy_status_irq.sv
`timescale 1ns/1ns
`default_nettype none
`include "phy_irq_cfg.svh"
module test_phy_status_irq
  import phy_irq_pkg::*;
;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  reg_word_t  reg_wdata = 16'h0000;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  reg_word_t  reg_rdata;
  logic       link_up = 1'b0;
  logic       jabber = 1'b0;
  logic       negotiation_done = 1'b0;
  logic       remote_fault_rx = 1'b0;
  logic       loopback_on = 1'b0;
  logic       full_duplex = 1'b0;
  logic       speed_10 = 1'b0;
  logic       false_carrier_event, rx_error_event, host_irq_phy, line_busy;
  logic       burst_fc = 1'b0;
  logic       burst_rx = 1'b0;
  logic [9:0] burst_len = 10'h000;
  int         n_errors = 0;
  int         samples_checked = 0;

  always #20 clock = ~clock;

  phy_status_irq #(.CNT_W(8)) phy_status_irq_i (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .link_up(link_up), .jabber(jabber), .negotiation_done(negotiation_done),
    .remote_fault_rx(remote_fault_rx), .loopback_on(loopback_on), .full_duplex(full_duplex),
    .speed_10(speed_10), .false_carrier_event(false_carrier_event),
    .rx_error_event(rx_error_event), .host_irq_phy(host_irq_phy));

  line_model line_model_i (.clock(clock), .srst(srst), .start_fc(burst_fc), .start_rx(burst_rx),
    .length(burst_len), .false_carrier_event(false_carrier_event),
    .rx_error_event(rx_error_event), .busy(line_busy));

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input reg_word_t exp, input reg_word_t got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The flag is a level held until cleared, so a few cycles of slack are safe
  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge clock);
    #1;
    samples_checked++;
    if (host_irq_phy !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED host_irq_phy expected %b seen %b", exp, host_irq_phy);
    end
  endtask

  task automatic wr(input logic [7:0] a, input reg_word_t d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input reg_word_t exp, input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  // Called just after a rising edge
  task automatic burst(input logic rx, input logic [9:0] n);
    int k;
    burst_rx  <= rx;
    burst_fc  <= ~rx;
    burst_len <= n;
    @(posedge clock);
    burst_fc <= 1'b0;
    burst_rx <= 1'b0;
    for (k = 0; k < 2000 && (line_busy || k == 0); k++)
      @(posedge clock);
    if (line_busy)
    begin
      n_errors++;
      test_done();
    end
  endtask

  task automatic fire(input int i);
    @(posedge clock);
    case (i)
      `EVT_LINK:          link_up <= ~link_up;
      `EVT_JABBER:        jabber <= 1'b1;
      `EVT_REMOTE_FAULT:  remote_fault_rx <= 1'b1;
      `EVT_NEG_DONE:      negotiation_done <= 1'b1;
      `EVT_FALSE_CARRIER: burst(1'b0, 10'd128);
      default:            burst(1'b1, 10'd128);
    endcase
    @(posedge clock);
    jabber           <= 1'b0;
    remote_fault_rx  <= 1'b0;
    negotiation_done <= 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    rd(`ADDR_IRQ_CONTROL, 16'h0000, "control reset");
    rd(`ADDR_IRQ_STATUS, 16'h0000, "status reset");
    @(posedge clock);
    link_up          <= 1'b1;
    jabber           <= 1'b1;
    negotiation_done <= 1'b1;
    loopback_on      <= 1'b1;
    full_duplex      <= 1'b1;
    speed_10         <= 1'b1;
    remote_fault_rx  <= 1'b1;
    @(posedge clock);
    remote_fault_rx <= 1'b0;
    // Duplex and speed read back as driven; the summary does not gate them on the link
    rd(`ADDR_STATUS_SUMMARY, 16'h007f, "summary");
    rd(`ADDR_STATUS_SUMMARY, 16'h007f, "summary again");
    rd(`ADDR_BASIC_STATUS, 16'h0000, "basic status");
    rd(`ADDR_STATUS_SUMMARY, 16'h003f, "fault cleared");
    @(posedge clock);
    {link_up, jabber, negotiation_done, loopback_on, full_duplex, speed_10} <= 6'h00;
    rd(`ADDR_STATUS_SUMMARY, 16'h0000, "summary low");
    chk_irq(1'b0);
    wr(`ADDR_IRQ_CONTROL, 16'hffff);
    rd(`ADDR_IRQ_CONTROL, 16'h0003, "control");
    chk_irq(1'b1);
    wr(`ADDR_IRQ_CONTROL, 16'h0000);
    rd(`ADDR_IRQ_STATUS, 16'h8000, "pending");
    rd(`ADDR_IRQ_STATUS, 16'h0000, "pending cleared");
    chk_irq(1'b0);
    wr(`ADDR_IRQ_CONTROL, 16'h0001);
    rd(`ADDR_STATUS_SUMMARY, 16'h0000, "summary");
    chk_irq(1'b1);
    wr(`ADDR_IRQ_CONTROL, 16'h0000);
    rd(`ADDR_IRQ_STATUS, 16'h8000, "test pending");
    rd(`ADDR_IRQ_STATUS, 16'h0000, "test cleared");
    wr(`ADDR_IRQ_STATUS, 16'hffff);
    rd(`ADDR_IRQ_STATUS, 16'h7e00, "masks");
    wr(`ADDR_IRQ_CONTROL, 16'h0002);
    fire(`EVT_LINK);
    chk_irq(1'b0);
    wr(`ADDR_IRQ_CONTROL, 16'h0000);
    wr(`ADDR_IRQ_STATUS, 16'h0000);
    fire(`EVT_LINK);
    chk_irq(1'b0);
    wr(`ADDR_IRQ_CONTROL, 16'h0002);
    // Each source alone, with only its own mask open
    for (int i = 0; i < `EVT_COUNT; i++)
    begin
      wr(`ADDR_IRQ_STATUS, 16'h7e00 & ~(16'h0001 << (9 + i)));
      rd(`ADDR_BASIC_STATUS, 16'h0000, "basic status");
      fire(i);
      chk_irq(1'b1);
      rd(`ADDR_IRQ_STATUS, 16'hfe00 & ~(16'h0001 << (9 + i)), "event pending");
      chk_irq(1'b0);
    end
    rd(`ADDR_FALSE_CARRIER, 16'h0080, "false carrier count");
    rd(`ADDR_FALSE_CARRIER, 16'h0000, "false carrier cleared");
    wr(`ADDR_IRQ_STATUS, 16'h7a00);
    @(posedge clock);
    burst(1'b0, 10'd127);
    chk_irq(1'b0);
    @(posedge clock);
    burst(1'b0, 10'd1);
    chk_irq(1'b1);
    wr(`ADDR_FALSE_CARRIER, 16'h0000);
    rd(`ADDR_FALSE_CARRIER, 16'h0080, "false carrier write ignored");
    @(posedge clock);
    #1;
    chk("read data idle", 16'h0000, reg_rdata);
    rd(8'h00, 16'h0000, "unmapped");
    @(posedge clock);
    burst(1'b1, 10'd300);
    rd(`ADDR_RX_ERROR, 16'h00ff, "rx error saturated");
    rd(`ADDR_RX_ERROR, 16'h0000, "rx error cleared");
    test_done();
  end
endmodule // test_phy_status_irq
`default_nettype wire
